//--- design/supervisor_watchdog_reset_gating.sv
// Supervisor: power-on/manual reset timer, watchdog, chip-enable gating and AHB-Lite registers.
`timescale 1ns/1ps
`include "supervisor_defines.svh"

module supervisor_watchdog_reset_gating #(
  parameter logic [31:0] RESET_CYCLES = `RESET_CYCLES,
  parameter logic [31:0] WD_DEFAULT_CYCLES = `WD_DEFAULT_CYCLES,
  parameter logic [31:0] WD_PULSE_CYCLES = `WD_PULSE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire supervisor_pkg::sense_s sense,
  output supervisor_pkg::flags_s flags,
  output logic irq
);
  import supervisor_pkg::*;

  localparam logic [31:0] LEAD_CYCLES = 32'(`WD_LEAD_CYCLES);
  localparam logic [31:0] CE_HOLD_CYCLES = 32'(`CE_HOLD_CYCLES);
  localparam logic [31:0] CAP_PER_NF = 32'(`CAP_CYCLES_PER_NF);
  localparam int SW = $bits(sense_s);

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  // A change is accepted only when the second and third stages agree, which
  // also drops single-cycle glitches from the comparators.
  logic [SW-1:0] s1_r, s2_r, s3_r, stable_r, stable_nxt;
  sense_s in;

  always_comb begin
    stable_nxt = stable_r;
    if (s2_r == s3_r) begin
      stable_nxt = s3_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stable_r <= '0;
    end else begin
      s1_r <= sense;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= stable_nxt;
    end
  end

  assign in = sense_s'(stable_r);

  // ========================================================================
  // Reset timer
  // ========================================================================
  logic [31:0] rst_cnt_r, rst_cnt_nxt;
  logic reset_n_r, reset_n_nxt, gate_open;

  assign gate_open = in.supply_ok && in.manual_reset_n;

  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    reset_n_nxt = reset_n_r;
    if (!gate_open) begin
      rst_cnt_nxt = RESET_CYCLES;
      reset_n_nxt = 1'b0;
    end else if (rst_cnt_r != 32'h0000_0000) begin
      rst_cnt_nxt = rst_cnt_r - 32'h0000_0001;
      reset_n_nxt = 1'b0;
    end else begin
      reset_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_r <= RESET_CYCLES;
      reset_n_r <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      reset_n_r <= reset_n_nxt;
    end
  end

  // ========================================================================
  // Watchdog
  // ========================================================================
  logic [7:0] cap_nf_r, cap_nf_nxt;
  kick_level_e kick, kick_prev_r;
  wd_state_e wd_st_r, wd_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt, pulse_cnt_r, pulse_cnt_nxt, timeout;
  logic wd_enable, kick_change, watchdog_warning_pulse_n_n_r, watchdog_warning_pulse_n_n_nxt, wdo_n_r, wdo_n_nxt, wd_fault_evt;

  always_comb begin
    if (in.watchdog_kick_high) begin
      kick = KICK_HIGH;
    end else if (in.watchdog_kick_low) begin
      kick = KICK_LOW;
    end else begin
      kick = KICK_MID;
    end
  end

  // A zero capacitor value would give no timeout at all, so it counts as one nanofarad.
  assign timeout = in.timeout_select ? WD_DEFAULT_CYCLES :
                   CAP_PER_NF * ((cap_nf_r == 8'h00) ? 32'h0000_0001 : {24'h000000, cap_nf_r});
  assign wd_enable = reset_n_r && !in.on_backup && (kick != KICK_MID);
  assign kick_change = (kick != kick_prev_r);

  always_comb begin
    wd_nxt = wd_st_r;
    wd_cnt_nxt = wd_cnt_r;
    pulse_cnt_nxt = (pulse_cnt_r != 32'h0000_0000) ? pulse_cnt_r - 32'h0000_0001 : pulse_cnt_r;
    wdo_n_nxt = wdo_n_r;
    wd_fault_evt = 1'b0;
    if (!wd_enable) begin
      wd_nxt = WD_IDLE;
      wd_cnt_nxt = 32'h0000_0000;
      pulse_cnt_nxt = 32'h0000_0000;
      wdo_n_nxt = 1'b1;
    end else if (kick_change) begin
      wd_nxt = WD_COUNT;
      wd_cnt_nxt = 32'h0000_0000;
      pulse_cnt_nxt = 32'h0000_0000;
      wdo_n_nxt = 1'b1;
    end else begin
      case (wd_st_r)
        WD_IDLE: begin
          wd_nxt = WD_COUNT;
          wd_cnt_nxt = 32'h0000_0000;
        end
        WD_COUNT: begin
          wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
          if (wd_cnt_nxt >= timeout) begin
            wd_nxt = WD_LEAD;
            wd_cnt_nxt = 32'h0000_0000;
            pulse_cnt_nxt = WD_PULSE_CYCLES;
          end
        end
        WD_LEAD: begin
          wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
          if (wd_cnt_nxt >= LEAD_CYCLES) begin
            wd_nxt = WD_FAULT;
            wdo_n_nxt = 1'b0;
            wd_fault_evt = 1'b1;
          end
        end
        WD_FAULT: begin
          wdo_n_nxt = 1'b0;
        end
        default: wd_nxt = WD_IDLE;
      endcase
    end
    watchdog_warning_pulse_n_n_nxt = (pulse_cnt_nxt == 32'h0000_0000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_st_r <= WD_IDLE;
      wd_cnt_r <= 32'h0000_0000;
      pulse_cnt_r <= 32'h0000_0000;
      wdo_n_r <= 1'b1;
      watchdog_warning_pulse_n_n_r <= 1'b1;
      kick_prev_r <= KICK_MID;
    end else begin
      wd_st_r <= wd_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      wdo_n_r <= wdo_n_nxt;
      watchdog_warning_pulse_n_n_r <= watchdog_warning_pulse_n_n_nxt;
      kick_prev_r <= kick;
    end
  end

  // ========================================================================
  // Chip-enable gating and status pins
  // ========================================================================
  logic [31:0] ce_hold_r, ce_hold_nxt;
  logic gate_open_d_r, ce_n_r, ce_n_nxt;

  always_comb begin
    ce_hold_nxt = (ce_hold_r != 32'h0000_0000) ? ce_hold_r - 32'h0000_0001 : ce_hold_r;
    if (gate_open_d_r && !gate_open && !in.chip_enable_in_n) begin
      ce_hold_nxt = CE_HOLD_CYCLES;
    end
    if (in.chip_enable_in_n || gate_open) begin
      ce_hold_nxt = 32'h0000_0000;
    end
    if (in.chip_enable_in_n) begin
      ce_n_nxt = 1'b1;
    end else if (gate_open) begin
      ce_n_nxt = 1'b0;
    end else begin
      ce_n_nxt = (ce_hold_nxt == 32'h0000_0000);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_hold_r <= 32'h0000_0000;
      gate_open_d_r <= 1'b0;
      ce_n_r <= 1'b1;
    end else begin
      ce_hold_r <= ce_hold_nxt;
      gate_open_d_r <= gate_open;
      ce_n_r <= ce_n_nxt;
    end
  end

  flags_s flags_r, flags_nxt;

  always_comb begin
    flags_nxt.reset_n = reset_n_nxt;
    flags_nxt.watchdog_fault_n = wdo_n_nxt;
    flags_nxt.watchdog_warning_pulse_n = watchdog_warning_pulse_n_n_nxt;
    flags_nxt.early_supply_warning_n = in.supply_warn_ok;
    flags_nxt.power_fail_flag_n = in.power_fail_sense;
    flags_nxt.battery_on_flag = in.on_backup;
    flags_nxt.chip_enable_out_n = ce_n_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '{reset_n: 1'b0, watchdog_fault_n: 1'b1, watchdog_warning_pulse_n: 1'b1,
                   early_supply_warning_n: 1'b0, power_fail_flag_n: 1'b0, battery_on_flag: 1'b0,
                   chip_enable_out_n: 1'b1};
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  // ========================================================================
  // AHB-Lite registers and interrupt
  // ========================================================================
  logic [`IRQ_W-1:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt, evt;
  logic wr_pend_r, wr_pend_nxt;
  logic [11:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign evt = {reset_n_nxt && !reset_n_r, !in.power_fail_sense && flags_r.power_fail_flag_n,
                !in.supply_warn_ok && flags_r.early_supply_warning_n, wd_fault_evt};

  always_comb begin
    wr_pend_nxt = take && hwrite;
    wr_addr_nxt = haddr[11:0];
    rdata_nxt = 32'h0000_0000;
    cap_nf_nxt = cap_nf_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt = irq_st_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `REG_CTRL_OFS: cap_nf_nxt = hwdata[`CTRL_CAP_NF_LSB +: `CTRL_CAP_NF_W];
        `REG_IRQ_STATUS_OFS: irq_st_nxt = irq_st_r & ~hwdata[`IRQ_W-1:0];
        `REG_IRQ_MASK_OFS: irq_mask_nxt = hwdata[`IRQ_W-1:0];
        default: ;
      endcase
    end
    // Events are applied after the clear so a coincident event is kept.
    irq_st_nxt = irq_st_nxt | evt;
    if (take && !hwrite) begin
      case (haddr[11:0])
        `REG_CTRL_OFS: rdata_nxt = {24'h000000, cap_nf_r};
        `REG_STATE_OFS: rdata_nxt = {22'h000000, wd_st_r, flags_r, in.timeout_select};
        `REG_IRQ_STATUS_OFS: rdata_nxt = {28'h0000000, irq_st_r};
        `REG_IRQ_MASK_OFS: rdata_nxt = {28'h0000000, irq_mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      rdata_r <= 32'h0000_0000;
      cap_nf_r <= `CTRL_RESET;
      irq_mask_r <= `IRQ_MASK_RESET;
      irq_st_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
      cap_nf_r <= cap_nf_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_st_r <= irq_st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign irq = |(irq_st_r & irq_mask_r);

  // ========================================================================
  // Checks
  // ========================================================================
  chk_battery_on_flag_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 flags.battery_on_flag == $past(in.on_backup)) else $error("battery flag does not follow backup");
  chk_pfail_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(in.power_fail_sense) |=> !flags.power_fail_flag_n) else $error("power fail flag missed");
  chk_supply_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !in.supply_ok |=> !flags.reset_n ##1 !flags.reset_n) else $error("reset not held on low supply");
  chk_manual_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(in.manual_reset_n) && in.supply_ok |=> !flags.reset_n[*8]) else $error("manual reset hold too short");
  chk_wdo_in_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !reset_n_r |=> flags.watchdog_fault_n) else $error("fault output low during reset");
  chk_mid_disables: assert property (@(posedge hclk) disable iff (!hresetn)
    kick == KICK_MID |=> flags.watchdog_fault_n) else $error("fault output low with kick floating");
  chk_pulse_leads: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flags.watchdog_fault_n) |-> $past(flags.watchdog_warning_pulse_n, `WD_LEAD_CYCLES) == 1'b0
    && $past(flags.watchdog_warning_pulse_n, `WD_LEAD_CYCLES + 1)) else $error("pulse lead wrong");
  chk_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flags.watchdog_warning_pulse_n) |-> !flags.watchdog_warning_pulse_n[*2]) else $error("pulse too short");
  chk_kick_release: assert property (@(posedge hclk) disable iff (!hresetn)
    wd_enable && kick_change |=> flags.watchdog_fault_n) else $error("fault not released on kick");
  chk_ce_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    in.chip_enable_in_n |=> flags.chip_enable_out_n) else $error("enable out low with input high");
  chk_ce_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(gate_open) && !in.chip_enable_in_n |=> !flags.chip_enable_out_n ##[1:400] flags.chip_enable_out_n)
    else $error("enable hold wrong");
endmodule

//--- include/supervisor_defines.svh
// Offsets, field positions, reset values and timing counts of the supervisor block.
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses)
// ==========================================================================
`define REG_CTRL_OFS 12'h000
`define REG_STATE_OFS 12'h004
`define REG_IRQ_STATUS_OFS 12'h008
`define REG_IRQ_MASK_OFS 12'h00C

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define CTRL_CAP_NF_LSB 0
`define CTRL_CAP_NF_W 8
`define CTRL_RESET 8'h0A
`define IRQ_WD_FAULT_BIT 0
`define IRQ_EARLY_WARN_BIT 1
`define IRQ_POWER_FAIL_BIT 2
`define IRQ_RESET_DONE_BIT 3
`define IRQ_W 4
`define IRQ_MASK_RESET 4'h0

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_HZ 20000000
`define RESET_TIME_MS 200
`define WD_DEFAULT_TIME_MS 1600
`define WD_PULSE_TIME_MS 1
`define WD_LEAD_TIME_NS 70
`define CE_HOLD_TIME_US 15
`define CAP_TENTH_MS_PER_NF 21
`define RESET_CYCLES (`CLK_HZ / 1000 * `RESET_TIME_MS)
`define WD_DEFAULT_CYCLES (`CLK_HZ / 1000 * `WD_DEFAULT_TIME_MS)
`define WD_PULSE_CYCLES (`CLK_HZ / 1000 * `WD_PULSE_TIME_MS)
`define WD_LEAD_CYCLES ((`WD_LEAD_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define CE_HOLD_CYCLES (`CE_HOLD_TIME_US * (`CLK_HZ / 1000000))
`define CAP_CYCLES_PER_NF (`CAP_TENTH_MS_PER_NF * (`CLK_HZ / 10000))

`endif

//--- include/supervisor_pkg.sv
// Types shared by the supervisor block and its bench.
package supervisor_pkg;

  // ========================================================================
  // Sensed comparator and pin levels
  // ========================================================================
  typedef struct packed {
    logic supply_ok;
    logic supply_warn_ok;
    logic manual_reset_n;
    logic power_fail_sense;
    logic watchdog_kick_high;
    logic watchdog_kick_low;
    logic timeout_select;
    logic on_backup;
    logic chip_enable_in_n;
  } sense_s;

  // ========================================================================
  // Supervisor outputs
  // ========================================================================
  typedef struct packed {
    logic reset_n;
    logic watchdog_fault_n;
    logic watchdog_warning_pulse_n;
    logic early_supply_warning_n;
    logic power_fail_flag_n;
    logic battery_on_flag;
    logic chip_enable_out_n;
  } flags_s;

  typedef enum logic [1:0] {KICK_MID, KICK_LOW, KICK_HIGH} kick_level_e;

  typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_LEAD, WD_FAULT} wd_state_e;

endpackage

//--- tb/host_partner.sv
// Host processor and RAM model: drives the watchdog kick levels and the memory chip enable.
`timescale 1ns/1ps
module host_partner #(
  parameter int KICK_PERIOD = 50
) (
  input wire logic hclk,
  input wire logic [1:0] kick_mode,
  input wire logic ram_write,
  output logic kick_high,
  output logic kick_low,
  output logic chip_enable_in_n
);
  // ==========================================================================
  // Kick and chip enable
  // ==========================================================================
  // Modes: 0 floating (mid level), 1 toggling, 2 held high, 3 held low.
  int cnt = 0;
  logic level = 1'b0;
  initial begin
    kick_high = 1'b0;
    kick_low = 1'b0;
    chip_enable_in_n = 1'b1;
  end
  always @(posedge hclk) begin
    cnt <= (cnt == KICK_PERIOD - 1) ? 0 : cnt + 1;
    if (cnt == KICK_PERIOD - 1) begin
      level <= ~level;
    end
    kick_high <= (kick_mode == 2'h2) || (kick_mode == 2'h1 && level);
    kick_low <= (kick_mode == 2'h3) || (kick_mode == 2'h1 && !level);
    chip_enable_in_n <= ~ram_write;
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the supervisor block: reset timer, watchdog, chip-enable gating and registers.
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module tb_top;
  import supervisor_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  // Short counts keep the run small; the reset, default timeout and pulse expectations are derived from them.
  localparam logic [31:0] RST_CYC = 32'h32;
  localparam logic [31:0] WD_CYC = 32'hC8;
  localparam logic [31:0] PULSE_CYC = 32'hA;
  localparam int B_RST = 6;
  localparam int B_WDF = 5;
  localparam int B_WDP = 4;
  localparam int B_CE = 0;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic supply_ok, warn_ok, mr_n, pf_sense, tsel, on_backup, ram_write;
  logic kick_high, kick_low, ce_in_n;
  logic [1:0] kick_mode;
  sense_s sense;
  flags_s flags;
  int num_errors = 0;
  int checks = 0;
  int n, m;
  assign sense = {supply_ok, warn_ok, mr_n, pf_sense, kick_high, kick_low, tsel, on_backup, ce_in_n};
  always #25 hclk = ~hclk;
  supervisor_watchdog_reset_gating #(.RESET_CYCLES(RST_CYC), .WD_DEFAULT_CYCLES(WD_CYC),
    .WD_PULSE_CYCLES(PULSE_CYC)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense), .flags(flags), .irq(irq));
  host_partner i_host (.hclk(hclk), .kick_mode(kick_mode), .ram_write(ram_write), .kick_high(kick_high),
    .kick_low(kick_low), .chip_enable_in_n(ce_in_n));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  task automatic wait_bit(input int idx, input logic val, input int limit, output int cnt);
    cnt = 0;
    while (flags[idx] !== val && cnt < limit) begin
      cycles(1);
      cnt++;
    end
  endtask
  task automatic count_low(input int idx, input int span, output int lows);
    lows = 0;
    repeat (span) begin
      cycles(1);
      if (flags[idx] !== 1'b1) lows++;
    end
  endtask
  // The master holds each phase until it samples hready high; read data is taken at that edge.
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, addr};
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wdata;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    rdata = hrdata;
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    bus(1'b0, `REG_CTRL_OFS, 32'h0, rd);
    check_word("ctrl reset", 32'h0000000A, rd);
    bus(1'b0, 12'h100, 32'h0, rd);
    check_word("unmapped read", 32'h0, rd);
    check_bit("bus response", 1'b0, hresp);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h5, rd);
    bus(1'b0, `REG_IRQ_MASK_OFS, 32'h0, rd);
    check_word("irq mask", 32'h5, rd);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h0, rd);
    bus(1'b1, `REG_IRQ_STATUS_OFS, 32'hF, rd);
  endtask
  task automatic t_flags();
    @(posedge hclk);
    on_backup <= 1'b1;
    pf_sense <= 1'b0;
    warn_ok <= 1'b0;
    cycles(8);
    check_bit("battery on", 1'b1, flags.battery_on_flag);
    check_bit("power fail", 1'b0, flags.power_fail_flag_n);
    check_bit("reset beside power fail", 1'b1, flags.reset_n);
    check_bit("early warning", 1'b0, flags.early_supply_warning_n);
    @(posedge hclk);
    on_backup <= 1'b0;
    pf_sense <= 1'b1;
    warn_ok <= 1'b1;
    cycles(8);
    check_word("flags restored", 32'h3E, {26'h0, flags[B_RST:1]});
    bus(1'b0, `REG_IRQ_STATUS_OFS, 32'h0, rd);
    check_word("warning events", 32'h6, rd);
    bus(1'b1, `REG_IRQ_STATUS_OFS, 32'h6, rd);
    bus(1'b0, `REG_IRQ_STATUS_OFS, 32'h0, rd);
    check_word("status cleared", 32'h0, rd);
  endtask
  task automatic t_kick_ok();
    count_low(B_WDF, 600, n);
    count_low(B_WDP, 300, m);
    check_range("fault lows while kicked", 0, 0, n + m);
  endtask
  task automatic t_timeout(input int expect_cyc);
    @(posedge hclk);
    kick_mode <= 2'h0;
    cycles(10);
    kick_mode <= 2'h2;
    wait_bit(B_WDP, 1'b0, expect_cyc + 400, n);
    check_range("timeout", expect_cyc, expect_cyc + 10, n);
    cycles(1);
    check_bit("fault before lead", 1'b1, flags.watchdog_fault_n);
    cycles(1);
    check_bit("fault after lead", 1'b0, flags.watchdog_fault_n);
    wait_bit(B_WDP, 1'b1, 40, n);
    check_range("pulse width", PULSE_CYC, PULSE_CYC + 2, n + 2);
  endtask
  task automatic t_fault_hold();
    count_low(B_WDF, 100, n);
    check_range("fault held", 100, 100, n);
    bus(1'b0, `REG_IRQ_STATUS_OFS, 32'h0, rd);
    check_word("fault event", 32'h1, rd);
    check_bit("irq masked", 1'b0, irq);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h1, rd);
    check_bit("irq unmasked", 1'b1, irq);
    bus(1'b1, `REG_IRQ_STATUS_OFS, 32'h1, rd);
    check_bit("irq cleared", 1'b0, irq);
    bus(1'b1, `REG_IRQ_MASK_OFS, 32'h0, rd);
    @(posedge hclk);
    kick_mode <= 2'h3;
    wait_bit(B_WDF, 1'b1, 12, n);
    check_bit("fault released", 1'b1, flags.watchdog_fault_n);
    kick_mode <= 2'h1;
  endtask
  task automatic t_kick_mid();
    @(posedge hclk);
    kick_mode <= 2'h0;
    count_low(B_WDF, 400, n);
    count_low(B_WDP, 200, m);
    check_range("lows while floating", 0, 0, n + m);
    kick_mode <= 2'h1;
  endtask
  task automatic t_manual_reset();
    @(posedge hclk);
    kick_mode <= 2'h2;
    ram_write <= 1'b1;
    mr_n <= 1'b0;
    cycles(10);
    check_bit("reset by button", 1'b0, flags.reset_n);
    check_bit("pulse in reset", 1'b1, flags.watchdog_warning_pulse_n);
    count_low(B_WDF, 400, n);
    check_range("fault lows in reset", 0, 0, n);
    check_bit("gating off in reset", 1'b1, flags.chip_enable_out_n);
    mr_n <= 1'b1;
    kick_mode <= 2'h1;
    wait_bit(B_RST, 1'b1, 400, n);
    check_range("button reset time", RST_CYC, RST_CYC + 10, n);
    cycles(2);
    check_bit("gating on", 1'b0, flags.chip_enable_out_n);
  endtask
  task automatic t_ce_hold();
    @(posedge hclk);
    supply_ok <= 1'b0;
    wait_bit(B_RST, 1'b0, 10, n);
    check_bit("reset on supply drop", 1'b0, flags.reset_n);
    wait_bit(B_CE, 1'b1, 400, m);
    check_range("write hold", `CE_HOLD_CYCLES, `CE_HOLD_CYCLES + 10, n + m);
    supply_ok <= 1'b1;
    wait_bit(B_RST, 1'b1, 200, n);
    check_range("supply reset time", RST_CYC, RST_CYC + 10, n);
    supply_ok <= 1'b0;
    cycles(20);
    check_bit("hold running", 1'b0, flags.chip_enable_out_n);
    ram_write <= 1'b0;
    wait_bit(B_CE, 1'b1, 10, n);
    check_bit("hold ended by input", 1'b1, flags.chip_enable_out_n);
    supply_ok <= 1'b1;
    wait_bit(B_RST, 1'b1, 200, n);
    check_bit("gating idle", 1'b1, flags.chip_enable_out_n);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b0, 1'b0, 1'b0, 2'h0, 3'h2, 32'h0, 32'h0};
    {supply_ok, warn_ok, mr_n, pf_sense, tsel, on_backup, ram_write} = 7'h7C;
    kick_mode = 2'h1;
    cycles(15);
    check_word("flags in reset", 32'h31, {25'h0, flags});
    check_bit("irq in reset", 1'b0, irq);
    @(posedge hclk);
    hresetn <= 1'b1;
    wait_bit(B_RST, 1'b1, 400, n);
    check_range("power-up reset time", RST_CYC, RST_CYC + 10, n);
    t_regs();
    t_flags();
    t_kick_ok();
    t_timeout(WD_CYC);
    t_fault_hold();
    t_kick_mid();
    t_manual_reset();
    t_ce_hold();
    bus(1'b1, `REG_CTRL_OFS, 32'h1, rd);
    tsel <= 1'b0;
    t_timeout(`CAP_CYCLES_PER_NF);
    print_verdict();
  end
  initial begin
    repeat (70000) @(posedge hclk);
    num_errors++;
    $display("unexpected run length: expected end within 70000 cycles, seen none");
    print_verdict();
  end
endmodule
